// ==== core/ddc_burst_timer.sv ====
`timescale 1ns/1ps
module ddc_burst_timer #(
    parameter int CNT_W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic start,
    input wire logic [CNT_W-1:0] beats,
    output logic busy
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;

    // a running burst ignores any new start
    always_comb begin
        count_next = count_reg;
        if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end else if (start) begin
            count_next = beats;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (en) begin
            count_reg <= count_next;
        end
    end

    assign busy = (count_reg != '0);
endmodule // ddc_burst_timer

// ==== core/ddc_controller.sv ====
`timescale 1ns/1ps
module ddc_controller (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    ddc_bus_if.ctrl bus,
    input wire logic reqValid,
    input wire ddc_pkg::ddc_cmd_e reqCmd,
    input wire logic [ddc_pkg::BG_W-1:0] reqBg,
    input wire logic [ddc_pkg::BA_W-1:0] reqBa,
    input wire logic [ddc_pkg::ADDR_W-1:0] reqAddr,
    output logic reqReady
);
    logic cke_reg, cke_next;
    logic [4:0] ctl_reg, ctl_next;
    logic [ddc_pkg::BG_W-1:0] bg_reg, bg_next;
    logic [ddc_pkg::BA_W-1:0] ba_reg, ba_next;
    logic [ddc_pkg::ADDR_W-1:0] a_reg, a_next;

    assign reqReady = 1'b1;

    // default each cycle is deselect with cke held, defined levels
    always_comb begin
        cke_next = cke_reg;
        ctl_next = 5'h1f;
        bg_next = '0;
        ba_next = '0;
        a_next = '0;
        if (reqValid) begin
            bg_next = reqBg;
            ba_next = reqBa;
            a_next = reqAddr;
            case (reqCmd)
                ddc_pkg::DDC_CMD_NOP: ctl_next = 5'h0f;
                ddc_pkg::DDC_CMD_MRS: begin
                    ctl_next = 5'h08;
                    a_next[ddc_pkg::POS_A17] = 1'b0;
                end
                ddc_pkg::DDC_CMD_REF: ctl_next = 5'h09;
                ddc_pkg::DDC_CMD_SRE: begin
                    ctl_next = 5'h09;
                    cke_next = 1'b0;
                end
                ddc_pkg::DDC_CMD_SRX, ddc_pkg::DDC_CMD_PDX: cke_next = 1'b1;
                ddc_pkg::DDC_CMD_PDE: cke_next = 1'b0;
                ddc_pkg::DDC_CMD_PRE: begin
                    ctl_next = 5'h0a;
                    a_next[ddc_pkg::POS_AP] = 1'b0;
                end
                ddc_pkg::DDC_CMD_PREA: begin
                    ctl_next = 5'h0a;
                    a_next[ddc_pkg::POS_AP] = 1'b1;
                end
                ddc_pkg::DDC_CMD_ACT: ctl_next = {2'b00,
                    reqAddr[ddc_pkg::POS_A14 +: 3]};
                ddc_pkg::DDC_CMD_WR: ctl_next = 5'h0c;
                ddc_pkg::DDC_CMD_RD: ctl_next = 5'h0d;
                ddc_pkg::DDC_CMD_ZQCL: begin
                    ctl_next = 5'h0e;
                    a_next[ddc_pkg::POS_AP] = 1'b1;
                end
                ddc_pkg::DDC_CMD_ZQCS: begin
                    ctl_next = 5'h0e;
                    a_next[ddc_pkg::POS_AP] = 1'b0;
                end
                default: ctl_next = 5'h1f;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cke_reg <= 1'b1;
            ctl_reg <= 5'h1f;
            bg_reg <= '0;
            ba_reg <= '0;
            a_reg <= '0;
        end else if (en) begin
            cke_reg <= cke_next;
            ctl_reg <= ctl_next;
            bg_reg <= bg_next;
            ba_reg <= ba_next;
            a_reg <= a_next;
        end
    end

    assign bus.cke = cke_reg;
    assign bus.csN = ctl_reg[4];
    assign bus.actN = ctl_reg[3];
    assign bus.rasN = ctl_reg[2];
    assign bus.casN = ctl_reg[1];
    assign bus.weN = ctl_reg[0];
    assign bus.bg = bg_reg;
    assign bus.ba = ba_reg;
    assign bus.addr = a_reg;
endmodule // ddc_controller

// ==== core/ddc_device.sv ====
`timescale 1ns/1ps
module ddc_device #(
    parameter int BG_W = ddc_pkg::BG_W,
    parameter int BA_W = ddc_pkg::BA_W,
    parameter int ADDR_W = ddc_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    ddc_bus_if.dev bus,
    input wire logic otfMode,
    input wire logic fixedBl8,
    output ddc_pkg::ddc_cmd_e cmd,
    output logic cmdValid,
    output logic [BG_W-1:0] bankGroup,
    output logic [BA_W-1:0] bank,
    output logic [ADDR_W-1:0] rowAddr,
    output logic [ddc_pkg::COL_W-1:0] colAddr,
    output logic [ADDR_W-1:0] mrOpcode,
    output logic autoPre,
    output logic allBanks,
    output logic [3:0] burstLen,
    output logic burstBusy,
    output logic selfRefresh,
    output logic powerDown
);
    typedef enum logic [2:0] {
        DDC_PS_ACTIVE = 3'h1,
        DDC_PS_SREF = 3'h2,
        DDC_PS_PDOWN = 3'h4
    } ddc_pstate_e;

    ddc_pstate_e ps_reg, ps_next;
    logic ckePrev_reg;
    ddc_pkg::ddc_cmd_e cmd_reg, cmd_next;
    logic valid_reg, valid_next;
    logic [BG_W-1:0] bg_reg, bg_next;
    logic [BA_W-1:0] ba_reg, ba_next;
    logic [ADDR_W-1:0] row_reg, row_next;
    logic [ddc_pkg::COL_W-1:0] col_reg, col_next;
    logic [ADDR_W-1:0] op_reg, op_next;
    logic ap_reg, ap_next;
    logic all_reg, all_next;
    logic [3:0] bl_reg, bl_next;
    ddc_pkg::ddc_cmd_e dec;
    logic startBurst;

    // classify one sampled pattern
    function automatic ddc_pkg::ddc_cmd_e decode(
        input logic pc, input logic cc, input logic cs, input logic act,
        input logic ras, input logic cas, input logic we);
        logic [2:0] s;
        s = {ras, cas, we};
        decode = ddc_pkg::DDC_CMD_ILL;
        if (pc && !cc) begin
            if (cs) decode = ddc_pkg::DDC_CMD_PDE;
            else if (act && s == 3'h1) decode = ddc_pkg::DDC_CMD_SRE;
        end else if (!pc && cc) begin
            if (cs || (act && s == 3'h7)) begin
                decode = ddc_pkg::DDC_CMD_SRX;
            end
        end else if (pc && cc) begin
            if (cs) decode = ddc_pkg::DDC_CMD_DES;
            else if (!act) decode = ddc_pkg::DDC_CMD_ACT;
            else begin
                case (s)
                    3'h0: decode = ddc_pkg::DDC_CMD_MRS;
                    3'h1: decode = ddc_pkg::DDC_CMD_REF;
                    3'h2: decode = ddc_pkg::DDC_CMD_PRE;
                    3'h3: decode = ddc_pkg::DDC_CMD_ILL;
                    3'h4: decode = ddc_pkg::DDC_CMD_WR;
                    3'h5: decode = ddc_pkg::DDC_CMD_RD;
                    3'h6: decode = ddc_pkg::DDC_CMD_ZQCS;
                    default: decode = ddc_pkg::DDC_CMD_NOP;
                endcase
            end
        end
        return decode;
    endfunction

    // all sampling at the rising edge only
    always_comb begin
        dec = decode(ckePrev_reg, bus.cke, bus.csN, bus.actN,
            bus.rasN, bus.casN, bus.weN);
        if (dec == ddc_pkg::DDC_CMD_PRE && bus.addr[ddc_pkg::POS_AP]) begin
            dec = ddc_pkg::DDC_CMD_PREA;
        end
        if (dec == ddc_pkg::DDC_CMD_ZQCS && bus.addr[ddc_pkg::POS_AP]) begin
            dec = ddc_pkg::DDC_CMD_ZQCL;
        end
        // transitions only legal from the matching power state
        case (ps_reg)
            DDC_PS_SREF: begin
                if (dec != ddc_pkg::DDC_CMD_SRX) begin
                    dec = ddc_pkg::DDC_CMD_ILL;
                end
            end
            DDC_PS_PDOWN: begin
                // power-down exit needs deselect, not nop
                if (dec == ddc_pkg::DDC_CMD_SRX && bus.csN) begin
                    dec = ddc_pkg::DDC_CMD_PDX;
                end else begin
                    dec = ddc_pkg::DDC_CMD_ILL;
                end
            end
            default: begin
                if (dec == ddc_pkg::DDC_CMD_SRX) begin
                    dec = ddc_pkg::DDC_CMD_ILL;
                end
            end
        endcase
    end

    always_comb begin
        ps_next = ps_reg;
        cmd_next = dec;
        valid_next = (dec != ddc_pkg::DDC_CMD_ILL)
            && (dec != ddc_pkg::DDC_CMD_DES);
        bg_next = bg_reg;
        ba_next = ba_reg;
        row_next = row_reg;
        col_next = col_reg;
        op_next = op_reg;
        ap_next = ap_reg;
        all_next = all_reg;
        bl_next = bl_reg;
        case (dec)
            ddc_pkg::DDC_CMD_SRE: ps_next = DDC_PS_SREF;
            ddc_pkg::DDC_CMD_PDE: ps_next = DDC_PS_PDOWN;
            ddc_pkg::DDC_CMD_SRX: ps_next = DDC_PS_ACTIVE;
            ddc_pkg::DDC_CMD_PDX: ps_next = DDC_PS_ACTIVE;
            ddc_pkg::DDC_CMD_MRS: begin
                bg_next = bus.bg;
                ba_next = bus.ba;
                op_next = bus.addr;
                op_next[ddc_pkg::POS_A17] = 1'b0;
            end
            ddc_pkg::DDC_CMD_ACT: begin
                bg_next = bus.bg;
                ba_next = bus.ba;
                row_next = bus.addr;
                row_next[ddc_pkg::POS_A14 +: 3] =
                    {bus.rasN, bus.casN, bus.weN};
            end
            ddc_pkg::DDC_CMD_PRE: begin
                bg_next = bus.bg;
                ba_next = bus.ba;
                all_next = 1'b0;
            end
            ddc_pkg::DDC_CMD_PREA: all_next = 1'b1;
            ddc_pkg::DDC_CMD_RD, ddc_pkg::DDC_CMD_WR: begin
                if (burstBusy) begin
                    valid_next = 1'b0;
                end else begin
                    bg_next = bus.bg;
                    ba_next = bus.ba;
                    col_next = bus.addr[ddc_pkg::COL_W-1:0];
                    ap_next = bus.addr[ddc_pkg::POS_AP];
                    if (otfMode) begin
                        bl_next = bus.addr[ddc_pkg::POS_BC]
                            ? ddc_pkg::BURST_BL8 : ddc_pkg::BURST_BC4;
                    end else begin
                        bl_next = fixedBl8
                            ? ddc_pkg::BURST_BL8 : ddc_pkg::BURST_BC4;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    assign startBurst = valid_next && (dec == ddc_pkg::DDC_CMD_RD
        || dec == ddc_pkg::DDC_CMD_WR);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_reg <= DDC_PS_ACTIVE;
            ckePrev_reg <= 1'b1;
            cmd_reg <= ddc_pkg::DDC_CMD_DES;
            valid_reg <= 1'b0;
            bg_reg <= '0;
            ba_reg <= '0;
            row_reg <= '0;
            col_reg <= '0;
            op_reg <= '0;
            ap_reg <= 1'b0;
            all_reg <= 1'b0;
            bl_reg <= ddc_pkg::BURST_BL8;
        end else if (en) begin
            ps_reg <= ps_next;
            ckePrev_reg <= bus.cke;
            cmd_reg <= cmd_next;
            valid_reg <= valid_next;
            bg_reg <= bg_next;
            ba_reg <= ba_next;
            row_reg <= row_next;
            col_reg <= col_next;
            op_reg <= op_next;
            ap_reg <= ap_next;
            all_reg <= all_next;
            bl_reg <= bl_next;
        end
    end

    // burst runs its full length
    ddc_burst_timer #(.CNT_W(4)) u_ddc_burst_timer (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .start(startBurst),
        .beats(bl_next),
        .busy(burstBusy)
    );

    assign cmd = cmd_reg;
    assign cmdValid = valid_reg;
    assign bankGroup = bg_reg;
    assign bank = ba_reg;
    assign rowAddr = row_reg;
    assign colAddr = col_reg;
    assign mrOpcode = op_reg;
    assign autoPre = ap_reg;
    assign allBanks = all_reg;
    assign burstLen = bl_reg;
    assign selfRefresh = (ps_reg == DDC_PS_SREF);
    assign powerDown = (ps_reg == DDC_PS_PDOWN);
endmodule // ddc_device

// ==== include/ddc_bus_if.sv ====
`timescale 1ns/1ps
interface ddc_bus_if;
    logic cke;
    logic csN;
    logic actN;
    logic rasN;
    logic casN;
    logic weN;
    logic [ddc_pkg::BG_W-1:0] bg;
    logic [ddc_pkg::BA_W-1:0] ba;
    logic [ddc_pkg::ADDR_W-1:0] addr;
    modport ctrl (output cke, csN, actN, rasN, casN, weN, bg, ba, addr);
    modport dev (input cke, csN, actN, rasN, casN, weN, bg, ba, addr);
endinterface

// ==== include/ddc_pkg.sv ====
package ddc_pkg;
    // sizing of the sampled command/address bus
    localparam int BG_W = 2;
    localparam int BA_W = 2;
    localparam int ADDR_W = 18;
    // address bit positions
    localparam int POS_AP = 10;
    localparam int POS_BC = 12;
    localparam int POS_A14 = 14;
    localparam int POS_A17 = 17;
    localparam int COL_W = 10;
    // burst lengths in data beats
    localparam logic [3:0] BURST_BC4 = 4'h4;
    localparam logic [3:0] BURST_BL8 = 4'h8;
    // decoded command codes
    typedef enum logic [3:0] {
        DDC_CMD_DES = 4'h0,
        DDC_CMD_NOP = 4'h1,
        DDC_CMD_MRS = 4'h2,
        DDC_CMD_REF = 4'h3,
        DDC_CMD_SRE = 4'h4,
        DDC_CMD_SRX = 4'h5,
        DDC_CMD_PRE = 4'h6,
        DDC_CMD_PREA = 4'h7,
        DDC_CMD_ACT = 4'h8,
        DDC_CMD_WR = 4'h9,
        DDC_CMD_RD = 4'ha,
        DDC_CMD_PDE = 4'hb,
        DDC_CMD_PDX = 4'hc,
        DDC_CMD_ZQCL = 4'hd,
        DDC_CMD_ZQCS = 4'he,
        DDC_CMD_ILL = 4'hf
    } ddc_cmd_e;
endpackage

// ==== testbench/ddc_properties.sv ====
`timescale 1ns/1ps
module ddc_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic csN,
    input wire logic actN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [ddc_pkg::BG_W-1:0] bg,
    input wire logic [ddc_pkg::BA_W-1:0] ba,
    input wire logic [ddc_pkg::ADDR_W-1:0] addr,
    input wire ddc_pkg::ddc_cmd_e cmd,
    input wire logic cmdValid,
    input wire logic [3:0] burstLen,
    input wire logic burstBusy,
    input wire logic selfRefresh,
    input wire logic powerDown
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // device in its active power state
    wire logic awake = !selfRefresh && !powerDown;
    wire logic cmdSel = !csN && actN;

    property p_act;
        !csN && !actN && cke && $past(cke) && awake
        |=> cmdValid && cmd == ddc_pkg::DDC_CMD_ACT;
    endproperty
    a_act: assert property (p_act)
        else $error("activate not decoded");
    property p_pre;
        cmdSel && !rasN && casN && !weN && cke && $past(cke) && awake
        |=> cmdValid && cmd == ($past(addr[10]) ? ddc_pkg::DDC_CMD_PREA
                                                : ddc_pkg::DDC_CMD_PRE);
    endproperty
    a_pre: assert property (p_pre)
        else $error("precharge decode wrong");
    property p_zq;
        cmdSel && rasN && casN && !weN && cke && $past(cke) && awake
        |=> cmdValid && cmd == ($past(addr[10]) ? ddc_pkg::DDC_CMD_ZQCL
                                                : ddc_pkg::DDC_CMD_ZQCS);
    endproperty
    a_zq: assert property (p_zq)
        else $error("calibration decode wrong");
    property p_rdwr;
        cmdSel && rasN && !casN && cke && $past(cke) && awake && !burstBusy
        |=> cmdValid && cmd == ($past(weN) ? ddc_pkg::DDC_CMD_RD
                                           : ddc_pkg::DDC_CMD_WR);
    endproperty
    a_rdwr: assert property (p_rdwr)
        else $error("read or write decode wrong");
    property p_busy4;
        cmdValid && cmd inside {ddc_pkg::DDC_CMD_RD, ddc_pkg::DDC_CMD_WR}
        && burstLen == 4'h4 |-> burstBusy [*4] ##1 (!burstBusy || cmdValid);
    endproperty
    a_busy4: assert property (p_busy4)
        else $error("chopped burst length wrong");
    property p_busy8;
        cmdValid && cmd inside {ddc_pkg::DDC_CMD_RD, ddc_pkg::DDC_CMD_WR}
        && burstLen == 4'h8 |-> burstBusy [*8] ##1 (!burstBusy || cmdValid);
    endproperty
    a_busy8: assert property (p_busy8)
        else $error("full burst length wrong");
    property p_des;
        csN && cke && $past(cke) |=> !cmdValid;
    endproperty
    a_des: assert property (p_des)
        else $error("command accepted while deselected");
    property p_sre;
        $fell(cke) && cmdSel && !rasN && !casN && weN && awake
        |=> cmdValid && cmd == ddc_pkg::DDC_CMD_SRE && selfRefresh;
    endproperty
    a_sre: assert property (p_sre)
        else $error("self refresh entry missed");
    property p_srx;
        selfRefresh && $rose(cke) && csN
        |=> cmdValid && cmd == ddc_pkg::DDC_CMD_SRX && !selfRefresh;
    endproperty
    a_srx: assert property (p_srx)
        else $error("self refresh exit missed");
    property p_pde;
        $fell(cke) && csN && awake
        |=> cmdValid && cmd == ddc_pkg::DDC_CMD_PDE && powerDown;
    endproperty
    a_pde: assert property (p_pde)
        else $error("power-down entry missed");
    property p_pdx;
        powerDown && $rose(cke) && csN
        |=> cmdValid && cmd == ddc_pkg::DDC_CMD_PDX && !powerDown;
    endproperty
    a_pdx: assert property (p_pdx)
        else $error("power-down exit missed");
endmodule // ddc_properties

// ==== testbench/ddr4_command_decoder_tb_top.sv ====
`timescale 1ns/1ps
module ddr4_command_decoder_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic otfMode = 1'b1;
    logic fixedBl8 = 1'b0;
    logic reqValid = 1'b0;
    ddc_pkg::ddc_cmd_e reqCmd = ddc_pkg::DDC_CMD_DES;
    logic [ddc_pkg::BG_W-1:0] reqBg = 2'h0;
    logic [ddc_pkg::BA_W-1:0] reqBa = 2'h0;
    logic [ddc_pkg::ADDR_W-1:0] reqAddr = 18'h00000;
    ddc_pkg::ddc_cmd_e cmd;
    logic cmdValid, autoPre, allBanks, burstBusy, selfRefresh, powerDown;
    logic [1:0] bankGroup, bank;
    logic [17:0] rowAddr, mrOpcode;
    logic [9:0] colAddr;
    logic [3:0] burstLen;
    logic reqReady;
    int miscompares = 0;
    int nChecks = 0;

    ddc_bus_if bus ();
    always #10 clk = ~clk;

    ddc_controller u_ddc_controller (.clk, .rst_n, .en(1'b1), .bus(bus),
        .reqValid, .reqCmd, .reqBg, .reqBa, .reqAddr, .reqReady);
    ddc_device u_ddc_device (.clk, .rst_n, .en(1'b1), .bus(bus), .otfMode,
        .fixedBl8, .cmd, .cmdValid, .bankGroup, .bank, .rowAddr, .colAddr,
        .mrOpcode, .autoPre, .allBanks, .burstLen, .burstBusy,
        .selfRefresh, .powerDown);
    ddc_properties u_ddc_properties (.clk, .rst_n, .cke(bus.cke),
        .csN(bus.csN), .actN(bus.actN), .rasN(bus.rasN), .casN(bus.casN),
        .weN(bus.weN), .bg(bus.bg), .ba(bus.ba), .addr(bus.addr), .cmd,
        .cmdValid, .burstLen, .burstBusy, .selfRefresh, .powerDown);

    task test_done;
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [17:0] got, input logic [17:0] exp, input string s);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    // one request, then look at the decode two cycles on
    task send(input ddc_pkg::ddc_cmd_e c, input logic [17:0] a,
              input logic v);
        @(negedge clk);
        reqValid = 1'b1;
        reqCmd = c;
        reqAddr = a;
        @(negedge clk);
        reqValid = 1'b0;
        @(negedge clk);
        chk(cmdValid, v, "valid");
        if (v) chk(cmd, c, "command");
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk(cmdValid, 1'b0, "reset valid");
        chk(burstLen, 4'h8, "reset burst");
        chk(reqReady, 1'b1, "request ready");
        reqBg = 2'h2;
        reqBa = 2'h1;
        send(ddc_pkg::DDC_CMD_MRS, 18'h23fff, 1'b1);
        chk(mrOpcode, 18'h03fff, "opcode");
        chk(bankGroup, 2'h2, "bank group");
        chk(bank, 2'h1, "bank");
        send(ddc_pkg::DDC_CMD_ACT, 18'h1c005, 1'b1);
        chk(rowAddr, 18'h1c005, "row");
        send(ddc_pkg::DDC_CMD_RD, 18'h016a5, 1'b1);
        chk(colAddr, 10'h2a5, "column");
        chk(autoPre, 1'b1, "auto precharge");
        chk(burstLen, ddc_pkg::BURST_BL8, "otf bl8");
        send(ddc_pkg::DDC_CMD_RD, 18'h016a5, 1'b0);
        chk(burstBusy, 1'b1, "burst kept");
        repeat (8) @(negedge clk);
        send(ddc_pkg::DDC_CMD_WR, 18'h00011, 1'b1);
        chk(burstLen, ddc_pkg::BURST_BC4, "otf bc4");
        chk(autoPre, 1'b0, "no auto precharge");
        repeat (6) @(negedge clk);
        otfMode = 1'b0;
        fixedBl8 = 1'b1;
        send(ddc_pkg::DDC_CMD_WR, 18'h00000, 1'b1);
        chk(burstLen, ddc_pkg::BURST_BL8, "fixed bl8");
        repeat (10) @(negedge clk);
        fixedBl8 = 1'b0;
        send(ddc_pkg::DDC_CMD_WR, 18'h01000, 1'b1);
        chk(burstLen, ddc_pkg::BURST_BC4, "fixed bc4");
        repeat (6) @(negedge clk);
        otfMode = 1'b1;
        reqBa = 2'h3;
        send(ddc_pkg::DDC_CMD_PRE, 18'h00000, 1'b1);
        chk(allBanks, 1'b0, "one bank");
        chk(bank, 2'h3, "precharge bank");
        send(ddc_pkg::DDC_CMD_PREA, 18'h00400, 1'b1);
        chk(allBanks, 1'b1, "all banks");
        send(ddc_pkg::DDC_CMD_ZQCL, 18'h00400, 1'b1);
        send(ddc_pkg::DDC_CMD_ZQCS, 18'h00000, 1'b1);
        send(ddc_pkg::DDC_CMD_REF, 18'h00000, 1'b1);
        send(ddc_pkg::DDC_CMD_NOP, 18'h00000, 1'b1);
        $display("test decode done");
        send(ddc_pkg::DDC_CMD_SRE, 18'h00000, 1'b1);
        chk(selfRefresh, 1'b1, "in self refresh");
        send(ddc_pkg::DDC_CMD_SRX, 18'h00000, 1'b1);
        chk(selfRefresh, 1'b0, "left self refresh");
        send(ddc_pkg::DDC_CMD_PDE, 18'h00000, 1'b1);
        chk(powerDown, 1'b1, "in power-down");
        send(ddc_pkg::DDC_CMD_PDX, 18'h00000, 1'b1);
        chk(powerDown, 1'b0, "left power-down");
        repeat (3) @(negedge clk);
        chk(cmdValid, 1'b0, "idle deselect");
        $display("test power done");
        test_done;
    end

    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        test_done;
    end
endmodule // ddr4_command_decoder_tb_top
